// File: rstseq_pkg.sv
// rstseq_pkg: constants, register map and state codes of the reset sequencer
// assumes a single 25 MHz clock that also stands in for the high-speed rc clock
package rstseq_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_NS    = 40;
    localparam int T_RC_NS   = 13000;
    localparam int T_REG_NS  = 15000;
    localparam int T_NVM_NS  = 150000;
    localparam int T_SVM_NS  = 2500;
    localparam int T_WDT_MS  = 8;
    localparam int SEQ_W     = 12;

    // least times: round up, never below one cycle
    function automatic logic [SEQ_W-1:0] ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        if (c < 1) begin
            c = 1;
        end
        return c[SEQ_W-1:0];
    endfunction : ns_to_cyc

    localparam logic [SEQ_W-1:0] RC_CYC  = ns_to_cyc(T_RC_NS);
    localparam logic [SEQ_W-1:0] REG_CYC = ns_to_cyc(T_REG_NS);
    localparam logic [SEQ_W-1:0] NVM_CYC = ns_to_cyc(T_NVM_NS);
    localparam logic [SEQ_W-1:0] SVM_CYC = ns_to_cyc(T_SVM_NS);
    localparam logic [SEQ_W-1:0] SEQ_ONE = 12'h001;
    localparam logic [SEQ_W-1:0] SEQ_ZERO = 12'h000;

    // watchdog: base period shifted by the prescale code, 8 ms .. 16.4 s
    localparam int WDT_BASE_DEF = T_WDT_MS * 1000000 / CLK_NS;
    localparam int WDT_CNT_W    = 29;
    localparam logic [3:0] WDT_PRESC_MAX = 4'hb;
    localparam logic [WDT_CNT_W-1:0] WDT_ONE = 29'h0000001;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SVM  = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;

    localparam int CTRL_SWRST   = 0;
    localparam int CTRL_KICK    = 1;
    localparam int CTRL_WDT_EN  = 2;
    localparam int CTRL_WDT_EXC = 3;
    localparam int CTRL_PRESC   = 4;

    localparam int SVM_THR      = 0;
    localparam int SVM_RST_EN   = 3;
    localparam int SVM_FALL_EN  = 4;
    localparam int SVM_RISE_EN  = 5;

    localparam int STAT_CAUSE   = 0;
    localparam int STAT_ABOVE   = 5;
    localparam int STAT_RAMINV  = 6;

    // thresholds ascend: 1.95, 2.0, 2.1, 2.2, 2.3, 2.4, 2.7, 3.0 V
    localparam logic [2:0] SVM_THR_DEF = 3'h1;

    // cause flag positions
    localparam int CAUSE_POR = 0;
    localparam int CAUSE_EXT = 1;
    localparam int CAUSE_SW  = 2;
    localparam int CAUSE_WDT = 3;
    localparam int CAUSE_SVM = 4;
    localparam logic [4:0] CAUSE_RST = 5'h01;

    localparam logic [31:0] RESET_VECTOR = 32'h00000038;

    typedef enum logic [5:0] {
        S_HOLD  = 6'h01,
        S_RC    = 6'h02,
        S_REG   = 6'h04,
        S_NVM   = 6'h08,
        S_SVM   = 6'h10,
        S_RUN   = 6'h20
    } rstseq_state_t;

endpackage : rstseq_pkg

// File: rstseq_wdt.sv
// rstseq_wdt: watchdog counter with prescaled period and one-cycle expiry pulse
// assumes clk is the high-speed rc clock and clr holds it while the chip is in reset
`timescale 1ns/1ps
module rstseq_wdt #(
    parameter int BASE_CYC = rstseq_pkg::WDT_BASE_DEF
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // control
    input  wire logic                          clr,
    input  wire logic                          en,
    input  wire logic [3:0]                    presc,
    input  wire logic                          kick,
    input  wire logic                          halt,
    // event
    output logic                               expire
);
    logic [rstseq_pkg::WDT_CNT_W-1:0] cnt_ff;
    logic [rstseq_pkg::WDT_CNT_W-1:0] limit;

    assign limit = rstseq_pkg::WDT_CNT_W'(BASE_CYC) << presc;

    // halt freezes the count so a debug stall resumes where it stopped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            expire <= 1'b0;
        end else begin
            expire <= 1'b0;
            if (clr || kick || !en) begin
                cnt_ff <= '0;
            end else if (!halt) begin
                if (cnt_ff >= limit - rstseq_pkg::WDT_ONE) begin
                    cnt_ff <= '0;
                    expire <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + rstseq_pkg::WDT_ONE;
                end
            end
        end
    end

endmodule : rstseq_wdt

// File: rstseq_svm.sv
// rstseq_svm: supply monitor crossing detector
// assumes supply_above comes from the analog comparator set at the chosen level
`timescale 1ns/1ps
module rstseq_svm (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // monitor
    input  wire logic       active,
    input  wire logic       supply_above,
    input  wire logic       fall_en,
    input  wire logic       rise_en,
    // results
    output logic            above,
    output logic            irq
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            above <= 1'b0;
            irq   <= 1'b0;
        end else begin
            above <= supply_above;
            irq   <= active && ((fall_en && above && !supply_above) ||
                                (rise_en && !above && supply_above));
        end
    end

endmodule : rstseq_svm

// File: rstseq_top.sv
// rstseq_top: chip reset sequencer, reset source merge, supply monitor and watchdog
// assumes all inputs are synchronous to clk; analog comparators and nvm sit outside
//
// How it works
// - start both oscillators before anything else
// - after rc start-up and default supply ok, regulators on
// - regulator settle, then nvm init fetches threshold
// - load threshold, pause, recheck supply, release cpu
// - released cpu boots, searching internal then external memory
// - five reset causes merge into chip reset
// - power-on holds reset through stabilisation sequence
// - supply below falling threshold restarts whole sequence
// - pin low holds reset; rising edge starts sequence
// - software reset anytime; ram marked invalid
// - monitor may reset chip on supply dip
// - monitor may interrupt on falling or rising crossing
// - monitor on from power-up, extends reset
// - eight software levels, power-up value from nvm
// - watchdog counts rc clock through prescaler
// - watchdog expiry without restart resets chip
// - watchdog cause flag survives the reset
// - optional watchdog exception instead of reset
// - after reset or wake, watchdog on at longest
// - software may disable watchdog or restart it
// - watchdog runs in doze, halts sleep and debug
// - cpu fetches from reset vector 0x38
`timescale 1ns/1ps
module rstseq_top #(
    parameter int WDT_BASE_CYC = rstseq_pkg::WDT_BASE_DEF
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // supply and reset sources
    input  wire logic        por_ok,
    input  wire logic        ext_rst_n,
    input  wire logic        supply_default_ok,
    input  wire logic        supply_above,
    // power state of the cpu
    input  wire logic        sleep,
    input  wire logic        dbg_stall,
    // nonvolatile init
    input  wire logic [2:0]  nvm_thr,
    output logic             nvm_init,
    // analog controls
    output logic             rc_osc_en,
    output logic             xtal_osc_en,
    output logic             reg_en,
    output logic [2:0]       svm_level,
    // cpu side
    output logic             cpu_rst_n,
    output logic [31:0]      reset_vector,
    output logic             svm_irq,
    output logic             wdt_exc,
    output logic             ram_invalid
);

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    rstseq_pkg::rstseq_state_t state_ff;
    logic [rstseq_pkg::SEQ_W-1:0] seq_cnt_ff;
    logic [2:0]  thr_ff;
    logic        svm_rst_en_ff;
    logic        svm_fall_en_ff;
    logic        svm_rise_en_ff;
    logic        wdt_en_ff;
    logic        wdt_exc_en_ff;
    logic [3:0]  wdt_presc_ff;
    logic [4:0]  cause_ff;
    logic        sleep_ff;
    logic        running;
    logic        wr_ctrl;
    logic        wr_svm;
    logic        wr_stat;
    logic        sw_rst;
    logic        kick;
    logic        wake;
    logic        wdt_expire;
    logic        wdt_rst;
    logic        svm_rst;
    logic        chip_rst;
    logic        svm_above;
    logic        svm_irq_w;
    logic        seq_done;
    logic [4:0]  cause_set;

    assign running  = (state_ff == rstseq_pkg::S_RUN);
    assign wr_ctrl  = reg_wr && (reg_addr == rstseq_pkg::ADDR_CTRL);
    assign wr_svm   = reg_wr && (reg_addr == rstseq_pkg::ADDR_SVM);
    assign wr_stat  = reg_wr && (reg_addr == rstseq_pkg::ADDR_STAT);
    assign sw_rst   = wr_ctrl && reg_wdata[rstseq_pkg::CTRL_SWRST] && running;
    assign kick     = wr_ctrl && reg_wdata[rstseq_pkg::CTRL_KICK];
    assign wake     = sleep_ff && !sleep;
    assign wdt_rst  = wdt_expire && !wdt_exc_en_ff;
    assign svm_rst  = running && svm_rst_en_ff && !supply_above;
    assign seq_done = (seq_cnt_ff == rstseq_pkg::SEQ_ONE);

    // five sources, any one of which drops the chip back to the hold state
    assign chip_rst = !por_ok || !ext_rst_n || sw_rst || wdt_rst || svm_rst;

    always_comb begin
        cause_set = '0;
        cause_set[rstseq_pkg::CAUSE_POR] = !por_ok;
        cause_set[rstseq_pkg::CAUSE_EXT] = !ext_rst_n;
        cause_set[rstseq_pkg::CAUSE_SW]  = sw_rst;
        cause_set[rstseq_pkg::CAUSE_WDT] = wdt_rst;
        cause_set[rstseq_pkg::CAUSE_SVM] = svm_rst;
    end

    // ---------------------------------------------------------------
    // power-up sequence
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff   <= rstseq_pkg::S_HOLD;
            seq_cnt_ff <= rstseq_pkg::SEQ_ZERO;
        end else if (chip_rst) begin
            state_ff   <= rstseq_pkg::S_HOLD;
            seq_cnt_ff <= rstseq_pkg::RC_CYC;
        end else begin
            if (!seq_done && seq_cnt_ff != rstseq_pkg::SEQ_ZERO) begin
                seq_cnt_ff <= seq_cnt_ff - rstseq_pkg::SEQ_ONE;
            end
            case (state_ff)
                rstseq_pkg::S_HOLD: begin
                    state_ff   <= rstseq_pkg::S_RC;
                    seq_cnt_ff <= rstseq_pkg::RC_CYC;
                end
                rstseq_pkg::S_RC: begin
                    // no regulator until the supply clears the default level
                    if (seq_done && supply_default_ok) begin
                        state_ff   <= rstseq_pkg::S_REG;
                        seq_cnt_ff <= rstseq_pkg::REG_CYC;
                    end
                end
                rstseq_pkg::S_REG: begin
                    if (seq_done) begin
                        state_ff   <= rstseq_pkg::S_NVM;
                        seq_cnt_ff <= rstseq_pkg::NVM_CYC;
                    end
                end
                rstseq_pkg::S_NVM: begin
                    if (seq_done) begin
                        state_ff   <= rstseq_pkg::S_SVM;
                        seq_cnt_ff <= rstseq_pkg::SVM_CYC;
                    end
                end
                rstseq_pkg::S_SVM: begin
                    // a low supply keeps the cpu in reset until it recovers
                    if (seq_done && supply_above) begin
                        state_ff <= rstseq_pkg::S_RUN;
                    end
                end
                rstseq_pkg::S_RUN: begin
                    state_ff <= rstseq_pkg::S_RUN;
                end
                default: begin
                    state_ff <= rstseq_pkg::S_HOLD;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // analog controls and cpu release
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rc_osc_en   <= 1'b0;
            xtal_osc_en <= 1'b0;
            reg_en      <= 1'b0;
            nvm_init    <= 1'b0;
            cpu_rst_n   <= 1'b0;
        end else begin
            rc_osc_en   <= !chip_rst && (state_ff != rstseq_pkg::S_HOLD);
            xtal_osc_en <= !chip_rst && (state_ff != rstseq_pkg::S_HOLD);
            reg_en      <= !chip_rst && (state_ff != rstseq_pkg::S_HOLD) &&
                           (state_ff != rstseq_pkg::S_RC);
            nvm_init    <= !chip_rst && (state_ff == rstseq_pkg::S_NVM);
            // the boot search starts from here once the cpu leaves reset
            cpu_rst_n   <= !chip_rst && running;
        end
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            reset_vector <= rstseq_pkg::RESET_VECTOR;
        end else begin
            reset_vector <= rstseq_pkg::RESET_VECTOR;
        end
    end

    // ---------------------------------------------------------------
    // supply monitor configuration
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            thr_ff         <= rstseq_pkg::SVM_THR_DEF;
            svm_rst_en_ff  <= 1'b0;
            svm_fall_en_ff <= 1'b0;
            svm_rise_en_ff <= 1'b0;
        end else if (!running) begin
            svm_rst_en_ff  <= 1'b0;
            svm_fall_en_ff <= 1'b0;
            svm_rise_en_ff <= 1'b0;
            if (state_ff == rstseq_pkg::S_HOLD) begin
                thr_ff <= rstseq_pkg::SVM_THR_DEF;
            end else if (state_ff == rstseq_pkg::S_NVM && seq_done) begin
                thr_ff <= nvm_thr;
            end
        end else if (wr_svm) begin
            thr_ff         <= reg_wdata[rstseq_pkg::SVM_THR +: 3];
            svm_rst_en_ff  <= reg_wdata[rstseq_pkg::SVM_RST_EN];
            svm_fall_en_ff <= reg_wdata[rstseq_pkg::SVM_FALL_EN];
            svm_rise_en_ff <= reg_wdata[rstseq_pkg::SVM_RISE_EN];
        end
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            svm_level <= rstseq_pkg::SVM_THR_DEF;
        end else begin
            svm_level <= thr_ff;
        end
    end

    // the comparator is only trusted while awake or in doze
    rstseq_svm u_svm (
        .clk          (clk),
        .rst_n        (rst_n_ff),
        .active       (running && !sleep),
        .supply_above (supply_above),
        .fall_en      (svm_fall_en_ff),
        .rise_en      (svm_rise_en_ff),
        .above        (svm_above),
        .irq          (svm_irq_w)
    );

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            svm_irq <= 1'b0;
        end else begin
            svm_irq <= svm_irq_w;
        end
    end

    // ---------------------------------------------------------------
    // watchdog
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            sleep_ff <= 1'b0;
        end else begin
            sleep_ff <= sleep;
        end
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            wdt_en_ff     <= 1'b1;
            wdt_exc_en_ff <= 1'b0;
            wdt_presc_ff  <= rstseq_pkg::WDT_PRESC_MAX;
        end else if (!running || wake) begin
            wdt_en_ff     <= 1'b1;
            wdt_exc_en_ff <= wdt_exc_en_ff && running;
            wdt_presc_ff  <= rstseq_pkg::WDT_PRESC_MAX;
        end else if (wr_ctrl) begin
            wdt_en_ff     <= reg_wdata[rstseq_pkg::CTRL_WDT_EN];
            wdt_exc_en_ff <= reg_wdata[rstseq_pkg::CTRL_WDT_EXC];
            if (reg_wdata[rstseq_pkg::CTRL_PRESC +: 4] > rstseq_pkg::WDT_PRESC_MAX) begin
                wdt_presc_ff <= rstseq_pkg::WDT_PRESC_MAX;
            end else begin
                wdt_presc_ff <= reg_wdata[rstseq_pkg::CTRL_PRESC +: 4];
            end
        end
    end

    // count restarts from zero on release and on wake, as if just kicked
    rstseq_wdt #(
        .BASE_CYC (WDT_BASE_CYC)
    ) u_wdt (
        .clk      (clk),
        .rst_n    (rst_n_ff),
        .clr      (!running || wake),
        .en       (wdt_en_ff),
        .presc    (wdt_presc_ff),
        .kick     (kick),
        .halt     (sleep || dbg_stall),
        .expire   (wdt_expire)
    );

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            wdt_exc <= 1'b0;
        end else begin
            wdt_exc <= wdt_expire && wdt_exc_en_ff;
        end
    end

    // ---------------------------------------------------------------
    // cause flags and ram validity
    // ---------------------------------------------------------------
    // flags live on the power-on reset only, so they outlast the chip reset
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            cause_ff <= rstseq_pkg::CAUSE_RST;
        end else begin
            if (wr_stat) begin
                cause_ff <= (cause_ff & ~reg_wdata[rstseq_pkg::STAT_CAUSE +: 5]) | cause_set;
            end else if (!por_ok) begin
                cause_ff <= cause_set;
            end else begin
                cause_ff <= cause_ff | cause_set;
            end
        end
    end

    // watchdog exception mode leaves memory intact, so only true resets mark it
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ram_invalid <= 1'b1;
        end else if (chip_rst) begin
            ram_invalid <= 1'b1;
        end else if (wr_stat && reg_wdata[rstseq_pkg::STAT_RAMINV]) begin
            ram_invalid <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // register read
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    rstseq_pkg::ADDR_CTRL: begin
                        reg_rdata[rstseq_pkg::CTRL_WDT_EN]     <= wdt_en_ff;
                        reg_rdata[rstseq_pkg::CTRL_WDT_EXC]    <= wdt_exc_en_ff;
                        reg_rdata[rstseq_pkg::CTRL_PRESC +: 4] <= wdt_presc_ff;
                    end
                    rstseq_pkg::ADDR_SVM: begin
                        reg_rdata[rstseq_pkg::SVM_THR +: 3]  <= thr_ff;
                        reg_rdata[rstseq_pkg::SVM_RST_EN]    <= svm_rst_en_ff;
                        reg_rdata[rstseq_pkg::SVM_FALL_EN]   <= svm_fall_en_ff;
                        reg_rdata[rstseq_pkg::SVM_RISE_EN]   <= svm_rise_en_ff;
                    end
                    rstseq_pkg::ADDR_STAT: begin
                        reg_rdata[rstseq_pkg::STAT_CAUSE +: 5] <= cause_ff;
                        reg_rdata[rstseq_pkg::STAT_ABOVE]      <= svm_above;
                        reg_rdata[rstseq_pkg::STAT_RAMINV]     <= ram_invalid;
                    end
                    default: begin
                        reg_rdata <= '0;
                    end
                endcase
            end
        end
    end

endmodule : rstseq_top

// File: rstseq_properties.sv
// rstseq_properties: port checks on rstseq_top
// assumes one clock domain with reset resetn
`timescale 1ns/1ps
module rstseq_properties (
    // watched ports
    input wire logic clk, resetn, reg_wr, ext_rst_n, supply_above, nvm_init, rc_osc_en,
    input wire logic xtal_osc_en, reg_en, cpu_rst_n, wdt_exc,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata, reset_vector
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_osc_first: assert property (reg_en |-> rc_osc_en && xtal_osc_en) else $error("osc order");
    a_nvm_done: assert property (cpu_rst_n |-> reg_en && !nvm_init) else $error("nvm order");
    a_nvm_powered: assert property (nvm_init |-> reg_en) else $error("nvm unpowered");
    a_release_ok: assert property ($rose(cpu_rst_n) |-> $past(supply_above, 2)) else $error("low supply");
    a_pin_holds: assert property (!ext_rst_n |=> !cpu_rst_n) else $error("pin reset");
    a_sw_reset: assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[0] && cpu_rst_n |=> !cpu_rst_n)
        else $error("sw reset");
    a_exc_runs: assert property (wdt_exc |=> cpu_rst_n) else $error("exc reset");
    a_vector: assert property (reset_vector == 32'h00000038) else $error("vector");
    c_release: cover property ($rose(cpu_rst_n));
    c_exc: cover property (wdt_exc);
    c_pin: cover property ($fell(ext_rst_n));
endmodule : rstseq_properties
bind rstseq_top rstseq_properties u_props (.*);

// File: rstseq_supply_model.sv
// rstseq_supply_model: ideal supply comparators
// assumes supply_code is on the svm_level scale
`timescale 1ns/1ps
module rstseq_supply_model (
    // rail and level
    input  wire logic [2:0] supply_code, svm_level,
    // comparators
    output logic            supply_above, supply_default_ok
);
    assign supply_above = supply_code >= svm_level;
    assign supply_default_ok = supply_code >= rstseq_pkg::SVM_THR_DEF;
endmodule : rstseq_supply_model

// File: rstseq_top_tb.sv
// rstseq_top_tb: self-checking bench of the reset sequencer
// assumes a watchdog base period of 20 cycles
`timescale 1ns/1ps
module rstseq_top_tb;
    logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ext_rst_n = 1'b1, por_ok = 1'b1;
    logic sleep = 1'b0, dbg_stall = 1'b0, supply_above, supply_default_ok, nvm_init, rc_osc_en;
    logic xtal_osc_en, reg_en, cpu_rst_n, svm_irq, wdt_exc, ram_invalid;
    logic [2:0] supply_code = 3'h7, nvm_thr = 3'h2, svm_level;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000, reg_rdata, reset_vector;
    int errors = 0, compares = 0, cyc = 0;
    always #20 clk = ~clk;
    rstseq_top #(.WDT_BASE_CYC(20)) i_dut (.*);
    rstseq_supply_model i_supply (.*);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        errors += (seen !== exp);
        if (seen !== exp) $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(posedge clk);
        {reg_wr, reg_rd} <= 2'b00;
        @(negedge clk);
        if (!w) chk(reg_rdata, d);
    endtask : bus
    task automatic boot(input logic [31:0] status);
        for (int n = 0; n < 6000 && cpu_rst_n !== 1'b1; n++) @(negedge clk);
        chk(cpu_rst_n, 1'b1);
        chk(reset_vector, 32'h00000038);
        chk(svm_level, nvm_thr);
        bus(1'b0, 8'h08, status);
        bus(1'b1, 8'h08, 32'h0000007f);
    endtask : boot
    task automatic t_power;
        boot(32'h00000061);
        bus(1'b0, 8'h08, 32'h00000020);
        bus(1'b0, 8'h0c, 32'h00000000);
        $display("power test done");
    endtask : t_power
    task automatic t_sw;
        bus(1'b1, 8'h00, 32'h00000001);
        chk({cpu_rst_n, ram_invalid}, 2'b01);
        boot(32'h00000064);
        $display("sw test done");
    endtask : t_sw
    task automatic t_wdt;
        // kick with the mode change so the old long count cannot linger
        bus(1'b1, 8'h00, 32'h0000000e);
        for (int n = 0; n < 90 && wdt_exc !== 1'b1; n++) @(negedge clk);
        chk({wdt_exc, cpu_rst_n}, 2'b11);
        bus(1'b1, 8'h00, 32'h00000006);
        repeat (17) @(negedge clk);
        chk(cpu_rst_n, 1'b1);
        for (int n = 0; n < 40 && cpu_rst_n !== 1'b0; n++) @(negedge clk);
        boot(32'h00000068);
        $display("wdt test done");
    endtask : t_wdt
    task automatic t_ext;
        @(posedge clk);
        {ext_rst_n, supply_code} <= {1'b0, 3'h1};
        repeat (3) @(negedge clk);
        chk(cpu_rst_n, 1'b0);
        @(posedge clk);
        ext_rst_n <= 1'b1;
        repeat (5000) @(negedge clk);
        chk(cpu_rst_n, 1'b0);
        @(posedge clk);
        supply_code <= 3'h7;
        boot(32'h00000062);
        $display("ext test done");
    endtask : t_ext
    task automatic t_mon;
        bus(1'b1, 8'h04, 32'h00000032);
        @(posedge clk);
        supply_code <= 3'h1;
        for (int n = 0; n < 4 && svm_irq !== 1'b1; n++) @(negedge clk);
        chk(svm_irq, 1'b1);
        @(negedge clk);
        chk({svm_irq, cpu_rst_n}, 2'b01);
        @(posedge clk);
        supply_code <= 3'h7;
        for (int n = 0; n < 4 && svm_irq !== 1'b1; n++) @(negedge clk);
        chk(svm_irq, 1'b1);
        bus(1'b1, 8'h04, 32'h0000000a);
        @(posedge clk);
        supply_code <= 3'h1;
        repeat (3) @(negedge clk);
        chk({cpu_rst_n, svm_irq}, 2'b00);
        @(posedge clk);
        supply_code <= 3'h7;
        boot(32'h00000070);
        @(posedge clk);
        por_ok <= 1'b0;
        @(posedge clk);
        por_ok <= 1'b1;
        @(negedge clk);
        chk(cpu_rst_n, 1'b0);
        boot(32'h00000061);
        $display("monitor test done");
    endtask : t_mon
    task automatic t_halt;
        int n;
        // one count before the stall, eighteen after it, then two cycles to the pulse
        bus(1'b1, 8'h00, 32'h0000000e);
        @(posedge clk);
        dbg_stall <= 1'b1;
        repeat (30) @(posedge clk);
        dbg_stall <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (n < 40 && wdt_exc !== 1'b1);
        chk(n, 21);
        bus(1'b1, 8'h00, 32'h00000000);
        repeat (30) @(negedge clk);
        chk(cpu_rst_n, 1'b1);
        @(posedge clk);
        sleep <= 1'b1;
        @(posedge clk);
        sleep <= 1'b0;
        bus(1'b0, 8'h00, 32'h000000b4);
        $display("halt test done");
    endtask : t_halt
    task automatic final_report(input int late);
        errors += late;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) final_report(1);
    end
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        t_power();
        t_sw();
        t_wdt();
        t_ext();
        t_mon();
        t_halt();
        final_report(0);
    end
endmodule : rstseq_top_tb
